// file: logic/mps_pin_mux.sv
/*
  pin function multiplexer: picks which peripheral owns each shared pin.
  assumes control bits come from their peripheral registers, reset to zero,
  and that pin inputs are synchronous to ref_clk_i.
*/
// Function
// - at reset the high address pin carries the high address bit
// - either timer output control bit set selects timer output, else address
// - internal master: chip select uses high address bit before the pin mux
// - clock zero pin defaults to clock; either mode high bit selects dma request
// - clock one pin carries transfer end zero while clock disable is set
// - receive pin carries clear to send one while its enable is set
// - receive or clear to send pin is further shared with port b bit seven
// - config bits 1 and 2 pick timer-serial, channel b or host triple set
// - at reset triple pins carry transfer end one, transmit and clock
// - config bit 1 swaps channel b and port a pins for host port signals
// - at reset the non host mode is always selected
// - config bit 6 gives port b bits 7..5 their pins, else the serial receive pair (bit 7) and async channel 1
`timescale 1ns/1ps
`default_nettype none

module mps_pin_mux (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control and configuration
  input wire mps_pkg::mps_ctrl_s ctrl_i,
  input wire logic [mps_pkg::CFG_W-1:0] sys_cfg_i,
  // high address and timer
  input wire logic cpu_high_address_i,
  input wire logic timer_out_i,
  output logic cs_high_address_o,
  output mps_pkg::mps_drv_s pin_high_addr_o,
  input wire logic pin_high_addr_i,
  // serial clock zero and dma request zero
  input wire mps_pkg::mps_drv_s serial_clock_zero_i,
  output logic serial_clock_zero_o,
  output logic dma_request_zero_n_o,
  output mps_pkg::mps_drv_s pin_clk_zero_o,
  input wire logic pin_clk_zero_i,
  // serial clock one and transfer end zero
  input wire mps_pkg::mps_drv_s serial_clock_one_i,
  output logic serial_clock_one_o,
  input wire logic transfer_end_zero_n_i,
  output mps_pkg::mps_drv_s pin_clk_one_o,
  input wire logic pin_clk_one_i,
  // clocked receive, clear to send one, port b bit seven
  output logic clocked_serial_receive_o,
  output logic clear_to_send_one_n_o,
  input wire mps_pkg::mps_drv_s port_b_bit_seven_i,
  output logic port_b_bit_seven_o,
  output mps_pkg::mps_drv_s pin_rx_sel_o,
  input wire logic pin_rx_sel_i,
  // async channel 1 data and port b bits six and five
  output logic async_one_receive_o,
  input wire logic async_one_transmit_i,
  input wire mps_pkg::mps_drv_s port_b_bit_six_i,
  output logic port_b_bit_six_o,
  input wire mps_pkg::mps_drv_s port_b_bit_five_i,
  output logic port_b_bit_five_o,
  output mps_pkg::mps_drv_s pin_b_six_o,
  input wire logic pin_b_six_i,
  output mps_pkg::mps_drv_s pin_b_five_o,
  input wire logic pin_b_five_i,
  // triple pin sources
  input wire logic transfer_end_one_n_i,
  input wire logic clocked_serial_transmit_i,
  input wire mps_pkg::mps_drv_s clocked_serial_clock_i,
  output logic clocked_serial_clock_o,
  input wire logic chan_b_request_to_send_n_i,
  input wire logic chan_b_terminal_ready_req_n_i,
  input wire logic chan_b_wait_req_n_i,
  input wire logic host_receive_ready_n_i,
  input wire logic host_transmit_ready_n_i,
  input wire logic host_interrupt_i,
  output mps_pkg::mps_drv_s [mps_pkg::TRI_PINS-1:0] pin_tri_o,
  input wire logic [mps_pkg::TRI_PINS-1:0] pin_tri_i,
  // channel b side of the mode pins
  input wire logic chan_b_transmit_data_i,
  output logic chan_b_receive_data_o,
  input wire mps_pkg::mps_drv_s chan_b_tx_rx_clock_i,
  output logic chan_b_tx_rx_clock_o,
  input wire mps_pkg::mps_drv_s chan_b_rx_tx_clock_i,
  output logic chan_b_rx_tx_clock_o,
  input wire mps_pkg::mps_drv_s chan_b_sync_i,
  output logic chan_b_sync_o,
  output logic chan_b_clear_to_send_n_o,
  output logic chan_b_carrier_detect_n_o,
  // host port side of the mode pins
  input wire logic host_driver_disable_n_i,
  output logic [mps_pkg::HOST_ADDR_W-1:0] host_address_o,
  output logic host_chip_select_n_o,
  output logic host_write_strobe_n_o,
  output logic host_read_strobe_n_o,
  output mps_pkg::mps_drv_s [mps_pkg::MODE_PINS-1:0] pin_mode_o,
  input wire logic [mps_pkg::MODE_PINS-1:0] pin_mode_i,
  // port a byte and host data byte
  input wire logic [mps_pkg::DATA_W-1:0] port_a_byte_out_i,
  input wire logic [mps_pkg::DATA_W-1:0] port_a_byte_oe_i,
  output logic [mps_pkg::DATA_W-1:0] port_a_byte_o,
  input wire logic [mps_pkg::DATA_W-1:0] host_data_byte_out_i,
  input wire logic [mps_pkg::DATA_W-1:0] host_data_byte_oe_i,
  output logic [mps_pkg::DATA_W-1:0] host_data_byte_o,
  output logic [mps_pkg::DATA_W-1:0] pin_data_o,
  output logic [mps_pkg::DATA_W-1:0] pin_data_oe_o,
  input wire logic [mps_pkg::DATA_W-1:0] pin_data_i
);
  import mps_pkg::*;

  mps_state_s st;
  mps_state_s next_st;
  logic sel_tout;
  logic sel_dreq;
  logic sel_transfer_end_zero;
  logic sel_cts;
  logic sel_port_b;
  logic sel_host;
  mps_tri_e tri_sel;
  logic rx_grp_in;
  mps_drv_s [MODE_PINS-1:0] mode_a_drv;
  mps_drv_s [MODE_PINS-1:0] mode_b_drv;
  logic [MODE_PINS-1:0] mode_a_in;
  logic [MODE_PINS-1:0] mode_b_in;

  // live drops on reset so every pin falls back to its default set
  always_comb begin
    next_st = st;
    next_st.live = 1'b1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // selects are combinational on the control bits, gated only by live
  assign sel_tout = st.live & (ctrl_i.timer_out_ctrl_hi | ctrl_i.timer_out_ctrl_lo);
  assign sel_dreq = st.live & (ctrl_i.dest_mode_hi | ctrl_i.source_mode_hi);
  assign sel_transfer_end_zero = st.live & ctrl_i.serial_clock_one_disable;
  assign sel_cts = st.live & ctrl_i.clear_to_send_one_enable;
  assign sel_port_b = st.live & sys_cfg_i[CFG_PORT_B_HI_BIT];
  assign sel_host = st.live & sys_cfg_i[CFG_HOST_MODE_BIT];
  assign tri_sel = st.live ? mps_tri_decode(sys_cfg_i[CFG_HOST_MODE_BIT], sys_cfg_i[CFG_CHAN_B_BIT])
                           : TRI_TIMER_SERIAL;

  // chip select never sees the timer output; an external master drives the pin
  assign cs_high_address_o = ctrl_i.ext_bus_master ? pin_high_addr_i : cpu_high_address_i;
  assign pin_high_addr_o.o = sel_tout ? timer_out_i : cpu_high_address_i;
  assign pin_high_addr_o.oe = ~ctrl_i.ext_bus_master;

  // clock zero versus dma request input
  mps_pin_sel #(.W(1), .IDLE(IDLE_LEVEL)) u_clk_zero (
    .sel_b_i(sel_dreq),
    .a_o_i(serial_clock_zero_i.o),
    .a_oe_i(serial_clock_zero_i.oe),
    .a_in_o(serial_clock_zero_o),
    .b_o_i(1'b0),
    .b_oe_i(1'b0),
    .b_in_o(dma_request_zero_n_o),
    .pin_o(pin_clk_zero_o.o),
    .pin_oe_o(pin_clk_zero_o.oe),
    .pin_i(pin_clk_zero_i)
  );

  // clock one versus transfer end zero output
  mps_pin_sel #(.W(1), .IDLE(IDLE_LEVEL)) u_clk_one (
    .sel_b_i(sel_transfer_end_zero),
    .a_o_i(serial_clock_one_i.o),
    .a_oe_i(serial_clock_one_i.oe),
    .a_in_o(serial_clock_one_o),
    .b_o_i(transfer_end_zero_n_i),
    .b_oe_i(1'b1),
    .b_in_o(),
    .pin_o(pin_clk_one_o.o),
    .pin_oe_o(pin_clk_one_o.oe),
    .pin_i(pin_clk_one_i)
  );

  // receive pin: port b bit seven outranks the serial pair
  mps_pin_sel #(.W(1), .IDLE(IDLE_LEVEL)) u_rx_sel (
    .sel_b_i(sel_port_b),
    .a_o_i(1'b0),
    .a_oe_i(1'b0),
    .a_in_o(rx_grp_in),
    .b_o_i(port_b_bit_seven_i.o),
    .b_oe_i(port_b_bit_seven_i.oe),
    .b_in_o(port_b_bit_seven_o),
    .pin_o(pin_rx_sel_o.o),
    .pin_oe_o(pin_rx_sel_o.oe),
    .pin_i(pin_rx_sel_i)
  );

  // both serial functions are inputs, so only the routing splits
  assign clocked_serial_receive_o = sel_cts ? IDLE_LEVEL : rx_grp_in;
  assign clear_to_send_one_n_o = sel_cts ? rx_grp_in : IDLE_LEVEL;

  // async channel 1 receive versus port b bit six
  mps_pin_sel #(.W(1), .IDLE(IDLE_LEVEL)) u_b_six (
    .sel_b_i(sel_port_b),
    .a_o_i(1'b0),
    .a_oe_i(1'b0),
    .a_in_o(async_one_receive_o),
    .b_o_i(port_b_bit_six_i.o),
    .b_oe_i(port_b_bit_six_i.oe),
    .b_in_o(port_b_bit_six_o),
    .pin_o(pin_b_six_o.o),
    .pin_oe_o(pin_b_six_o.oe),
    .pin_i(pin_b_six_i)
  );

  // async channel 1 transmit versus port b bit five
  mps_pin_sel #(.W(1), .IDLE(IDLE_LEVEL)) u_b_five (
    .sel_b_i(sel_port_b),
    .a_o_i(async_one_transmit_i),
    .a_oe_i(1'b1),
    .a_in_o(),
    .b_o_i(port_b_bit_five_i.o),
    .b_oe_i(port_b_bit_five_i.oe),
    .b_in_o(port_b_bit_five_o),
    .pin_o(pin_b_five_o.o),
    .pin_oe_o(pin_b_five_o.oe),
    .pin_i(pin_b_five_i)
  );

  // triple pins; only the clocked serial clock is ever an input
  always_comb begin
    pin_tri_o = '{default: DRV_OFF};
    clocked_serial_clock_o = IDLE_LEVEL;
    case (tri_sel)
      TRI_TIMER_SERIAL: begin
        pin_tri_o[0] = '{o: transfer_end_one_n_i, oe: 1'b1};
        pin_tri_o[1] = '{o: clocked_serial_transmit_i, oe: 1'b1};
        pin_tri_o[2] = clocked_serial_clock_i;
        clocked_serial_clock_o = pin_tri_i[2];
      end
      TRI_CHAN_B: begin
        pin_tri_o[0] = '{o: chan_b_request_to_send_n_i, oe: 1'b1};
        pin_tri_o[1] = '{o: chan_b_terminal_ready_req_n_i, oe: 1'b1};
        pin_tri_o[2] = '{o: chan_b_wait_req_n_i, oe: 1'b1};
      end
      TRI_HOST: begin
        pin_tri_o[0] = '{o: host_receive_ready_n_i, oe: 1'b1};
        pin_tri_o[1] = '{o: host_transmit_ready_n_i, oe: 1'b1};
        pin_tri_o[2] = '{o: host_interrupt_i, oe: 1'b1};
      end
      default: begin
        pin_tri_o = '{default: DRV_OFF};
      end
    endcase
  end

  // mode pin sources: channel b on side a, host port on side b
  assign mode_a_drv[0] = '{o: chan_b_transmit_data_i, oe: 1'b1};
  assign mode_a_drv[1] = DRV_OFF;
  assign mode_a_drv[2] = chan_b_tx_rx_clock_i;
  assign mode_a_drv[3] = chan_b_rx_tx_clock_i;
  assign mode_a_drv[4] = chan_b_sync_i;
  assign mode_a_drv[5] = DRV_OFF;
  assign mode_a_drv[6] = DRV_OFF;
  assign mode_b_drv[0] = '{o: host_driver_disable_n_i, oe: 1'b1};
  assign mode_b_drv[MODE_PINS-1:1] = '{default: DRV_OFF};

  // one selector per mode pin
  for (genvar p = 0; p < MODE_PINS; p++) begin : g_mode
    mps_pin_sel #(.W(1), .IDLE(IDLE_LEVEL)) u_mode (
      .sel_b_i(sel_host),
      .a_o_i(mode_a_drv[p].o),
      .a_oe_i(mode_a_drv[p].oe),
      .a_in_o(mode_a_in[p]),
      .b_o_i(mode_b_drv[p].o),
      .b_oe_i(mode_b_drv[p].oe),
      .b_in_o(mode_b_in[p]),
      .pin_o(pin_mode_o[p].o),
      .pin_oe_o(pin_mode_o[p].oe),
      .pin_i(pin_mode_i[p])
    );
  end

  // mode pin inputs fanned out to their owners
  assign chan_b_receive_data_o = mode_a_in[1];
  assign chan_b_tx_rx_clock_o = mode_a_in[2];
  assign chan_b_rx_tx_clock_o = mode_a_in[3];
  assign chan_b_sync_o = mode_a_in[4];
  assign chan_b_clear_to_send_n_o = mode_a_in[5];
  assign chan_b_carrier_detect_n_o = mode_a_in[6];
  assign host_address_o = {mode_b_in[3], mode_b_in[1], mode_b_in[2]}; // two, one, zero
  assign host_chip_select_n_o = mode_b_in[4];
  assign host_write_strobe_n_o = mode_b_in[5];
  assign host_read_strobe_n_o = mode_b_in[6];

  // port a byte versus host data byte
  mps_pin_sel #(.W(DATA_W), .IDLE(IDLE_LEVEL)) u_data (
    .sel_b_i(sel_host),
    .a_o_i(port_a_byte_out_i),
    .a_oe_i(port_a_byte_oe_i),
    .a_in_o(port_a_byte_o),
    .b_o_i(host_data_byte_out_i),
    .b_oe_i(host_data_byte_oe_i),
    .b_in_o(host_data_byte_o),
    .pin_o(pin_data_o),
    .pin_oe_o(pin_data_oe_o),
    .pin_i(pin_data_i)
  );

  // checks, sampled after reset release
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_defaults: assert property (!st.live |-> pin_high_addr_o.o == cpu_high_address_i
    && pin_clk_zero_o == serial_clock_zero_i && !pin_clk_one_o.oe == !serial_clock_one_i.oe)
    else $error("pins not at defaults after reset");
  a_tout_pick: assert property (st.live && (ctrl_i.timer_out_ctrl_hi || ctrl_i.timer_out_ctrl_lo)
    |-> pin_high_addr_o.o == timer_out_i)
    else $error("timer output not on high address pin");
  a_addr_pick: assert property (!(ctrl_i.timer_out_ctrl_hi || ctrl_i.timer_out_ctrl_lo)
    |-> pin_high_addr_o.o == cpu_high_address_i)
    else $error("high address bit not on its pin");
  a_cs_internal: assert property (!ctrl_i.ext_bus_master
    |-> cs_high_address_o == cpu_high_address_i && pin_high_addr_o.oe)
    else $error("chip select high address disturbed");
  a_dreq_route: assert property (sel_dreq |-> dma_request_zero_n_o == pin_clk_zero_i
    && !pin_clk_zero_o.oe && serial_clock_zero_o)
    else $error("dma request zero not routed");
  a_transfer_end_zero_route: assert property (st.live && ctrl_i.serial_clock_one_disable
    |-> pin_clk_one_o.o == transfer_end_zero_n_i && pin_clk_one_o.oe)
    else $error("transfer end zero not on clock one pin");
  a_cts_route: assert property (st.live && !sys_cfg_i[CFG_PORT_B_HI_BIT]
    |-> (ctrl_i.clear_to_send_one_enable ? clear_to_send_one_n_o : clocked_serial_receive_o)
        == pin_rx_sel_i)
    else $error("receive pin routed to wrong serial function");
  a_pb7_route: assert property (sel_port_b |-> port_b_bit_seven_o == pin_rx_sel_i
    && clear_to_send_one_n_o && clocked_serial_receive_o
    && pin_rx_sel_o == port_b_bit_seven_i)
    else $error("port b bit seven not on receive pin");
  a_tri_host: assert property (st.live && (sys_cfg_i[2:1] == 2'b11)
    |-> pin_tri_o[2].o == host_interrupt_i && pin_tri_o[0].o == host_receive_ready_n_i)
    else $error("host triple set not selected");
  a_tri_chan_b: assert property (st.live && (sys_cfg_i[2:1] == 2'b10)
    |-> pin_tri_o[1].o == chan_b_terminal_ready_req_n_i && pin_tri_o[2].oe)
    else $error("channel b triple set not selected");
  a_tri_default: assert property ((!st.live || !sys_cfg_i[CFG_CHAN_B_BIT])
    |-> pin_tri_o[1].o == clocked_serial_transmit_i && pin_tri_o[2] == clocked_serial_clock_i)
    else $error("default triple set missing");
  a_host_route: assert property (sel_host |-> pin_mode_o[0].o == host_driver_disable_n_i
    && host_chip_select_n_o == pin_mode_i[4] && host_data_byte_o == pin_data_i)
    else $error("host port pins not routed");
  a_host_reset: assert property ((!st.live || !sys_cfg_i[CFG_HOST_MODE_BIT])
    |-> pin_mode_o[0].o == chan_b_transmit_data_i && port_a_byte_o == pin_data_i
        && host_write_strobe_n_o)
    else $error("non host mode not selected");
  a_port_b_group: assert property (st.live && !sys_cfg_i[CFG_PORT_B_HI_BIT]
    |-> pin_b_five_o.o == async_one_transmit_i && async_one_receive_o == pin_b_six_i
        && port_b_bit_five_o)
    else $error("async channel 1 not on port b pins");
  a_follow_change: assert property (st.live && $changed(sys_cfg_i[CFG_HOST_MODE_BIT])
    |-> pin_mode_o[0].o == (sys_cfg_i[CFG_HOST_MODE_BIT] ? host_driver_disable_n_i
                                                         : chan_b_transmit_data_i))
    else $error("selection lagged a config change");

  c_tout: cover property (st.live && sel_tout ##1 !sel_tout);
  c_host_mode: cover property (tri_sel == TRI_HOST && sel_host);
  c_chan_b: cover property (tri_sel == TRI_CHAN_B);
  c_port_b: cover property (sel_port_b && sel_cts);

endmodule : mps_pin_mux

`default_nettype wire

// file: logic/mps_pkg.sv
/*
  shared constants, types and helpers of the multiplexed pin select block.
  assumes the control and configuration bits arrive from their owning
  peripherals already reset to zero and synchronous to ref_clk_i.
*/
package mps_pkg;

  // system configuration word
  localparam int CFG_W = 8;
  localparam int CFG_HOST_MODE_BIT = 1; // host port mode, also triple code msb
  localparam int CFG_CHAN_B_BIT = 2; // triple code lsb
  localparam int CFG_PORT_B_HI_BIT = 6; // port b bits 7..5 select

  // widths of the grouped pins
  localparam int TRI_PINS = 3;
  localparam int MODE_PINS = 7;
  localparam int DATA_W = 8;
  localparam int HOST_ADDR_W = 3;

  // level a deselected function input sees; high, so the active low inputs read inactive
  localparam logic IDLE_LEVEL = 1'b1;

  // pin drive: output value and output enable (high while driving)
  typedef struct packed {
    logic o;
    logic oe;
  } mps_drv_s;

  localparam mps_drv_s DRV_OFF = '{o: 1'b0, oe: 1'b0};

  // control bits owned by timer, dma, async channel 1 and bus arbiter
  typedef struct packed {
    logic timer_out_ctrl_hi;
    logic timer_out_ctrl_lo;
    logic dest_mode_hi;
    logic source_mode_hi;
    logic serial_clock_one_disable;
    logic clear_to_send_one_enable;
    logic ext_bus_master;
  } mps_ctrl_s;

  // function sets of the three triple pins
  typedef enum logic [1:0] {
    TRI_TIMER_SERIAL,
    TRI_CHAN_B,
    TRI_HOST
  } mps_tri_e;

  // whole state of the top module
  typedef struct packed {
    logic live;
  } mps_state_s;

  localparam mps_state_s STATE_RST = '{live: 1'b0};

  // codes 00 and 10 share the default set, bit 1 written first
  function automatic mps_tri_e mps_tri_decode(input logic bit1, input logic bit2);
    mps_tri_e r;
    r = TRI_TIMER_SERIAL;
    if (bit2) begin
      r = bit1 ? TRI_HOST : TRI_CHAN_B;
    end
    return r;
  endfunction : mps_tri_decode

endpackage : mps_pkg

// file: logic/mps_pin_sel.sv
/*
  two-way selector of one group of shared pins between two functions.
  assumes a deselected function wants a steady idle level on its input.
*/
`timescale 1ns/1ps
`default_nettype none

module mps_pin_sel #(
  parameter int W = 1,
  parameter logic IDLE = 1'b1
) (
  // select
  input wire logic sel_b_i,
  // function a
  input wire logic [W-1:0] a_o_i,
  input wire logic [W-1:0] a_oe_i,
  output logic [W-1:0] a_in_o,
  // function b
  input wire logic [W-1:0] b_o_i,
  input wire logic [W-1:0] b_oe_i,
  output logic [W-1:0] b_in_o,
  // pin side
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_o,
  input wire logic [W-1:0] pin_i
);

  // one mux per bit; purely combinational so a new select acts at once
  for (genvar g = 0; g < W; g++) begin : g_bit
    assign pin_o[g] = sel_b_i ? b_o_i[g] : a_o_i[g];
    assign pin_oe_o[g] = sel_b_i ? b_oe_i[g] : a_oe_i[g];
    assign a_in_o[g] = sel_b_i ? IDLE : pin_i[g];
    assign b_in_o[g] = sel_b_i ? pin_i[g] : IDLE;
  end

endmodule : mps_pin_sel

`default_nettype wire

// file: verif/mps_board.sv
/*
  board model of the shared pins: a pin shows the device drive while its
  enable is high, else the board source. assumes every pin has a board
  source, so an undriven pin never floats.
*/
`timescale 1ns/1ps
`default_nettype none

module mps_board #(
  parameter int W = 24
) (
  // device drive
  input wire logic [W-1:0] o_i,
  input wire logic [W-1:0] oe_i,
  // board source, bit 0 doubles as the external master's address bit
  input wire logic [W-1:0] ext_i,
  // resolved pin levels
  output logic [W-1:0] lvl_o
);
  // device wins where it drives; a fight on a pin is not modelled
  assign lvl_o = (o_i & oe_i) | (ext_i & ~oe_i);
endmodule : mps_board
`default_nettype wire

// file: verif/mps_pin_mux_test.sv
/*
  self-checking bench of the pin multiplexer with a board model on its pins.
  assumes selections are combinational and forced to defaults in reset.
*/
`timescale 1ns/1ps
`default_nettype none

module mps_pin_mux_test;
  import mps_pkg::*;
  logic ref_clk_i, rst_n_i, cpu_high_address_i, timer_out_i, transfer_end_zero_n_i, async_one_transmit_i;
  logic transfer_end_one_n_i, clocked_serial_transmit_i, chan_b_request_to_send_n_i, chan_b_terminal_ready_req_n_i;
  logic chan_b_wait_req_n_i, host_receive_ready_n_i, host_transmit_ready_n_i, host_interrupt_i;
  logic chan_b_transmit_data_i, host_driver_disable_n_i, pin_high_addr_i, pin_clk_zero_i, pin_clk_one_i;
  logic pin_rx_sel_i, pin_b_six_i, pin_b_five_i, cs_high_address_o, serial_clock_zero_o, dma_request_zero_n_o;
  logic serial_clock_one_o, clocked_serial_receive_o, clear_to_send_one_n_o, port_b_bit_seven_o;
  logic async_one_receive_o, port_b_bit_six_o, port_b_bit_five_o, clocked_serial_clock_o, chan_b_receive_data_o;
  logic chan_b_tx_rx_clock_o, chan_b_rx_tx_clock_o, chan_b_sync_o, chan_b_clear_to_send_n_o;
  logic chan_b_carrier_detect_n_o, host_chip_select_n_o, host_write_strobe_n_o, host_read_strobe_n_o;
  mps_ctrl_s ctrl_i;
  logic [CFG_W-1:0] sys_cfg_i;
  mps_drv_s pin_high_addr_o, pin_clk_zero_o, pin_clk_one_o, pin_rx_sel_o, pin_b_six_o, pin_b_five_o;
  mps_drv_s serial_clock_zero_i, serial_clock_one_i, port_b_bit_seven_i, port_b_bit_six_i, port_b_bit_five_i;
  mps_drv_s clocked_serial_clock_i, chan_b_tx_rx_clock_i, chan_b_rx_tx_clock_i, chan_b_sync_i;
  mps_drv_s [TRI_PINS-1:0] pin_tri_o;
  mps_drv_s [MODE_PINS-1:0] pin_mode_o;
  logic [TRI_PINS-1:0] pin_tri_i, t_o, t_oe;
  logic [MODE_PINS-1:0] pin_mode_i, m_o, m_oe;
  logic [HOST_ADDR_W-1:0] host_address_o;
  logic [DATA_W-1:0] port_a_byte_out_i, port_a_byte_oe_i, port_a_byte_o, host_data_byte_out_i;
  logic [DATA_W-1:0] host_data_byte_oe_i, host_data_byte_o, pin_data_o, pin_data_oe_o, pin_data_i;
  logic [23:0] p_o, p_oe, p_lvl, ext;
  logic [2:0] tri_exp [4];
  int miscompares, n_tests;

  mps_pin_mux i_dut (.ref_clk_i, .rst_n_i, .ctrl_i, .sys_cfg_i, .cpu_high_address_i, .timer_out_i,
    .cs_high_address_o, .pin_high_addr_o, .pin_high_addr_i, .serial_clock_zero_i, .serial_clock_zero_o,
    .dma_request_zero_n_o, .pin_clk_zero_o, .pin_clk_zero_i, .serial_clock_one_i, .serial_clock_one_o,
    .transfer_end_zero_n_i, .pin_clk_one_o, .pin_clk_one_i, .clocked_serial_receive_o, .clear_to_send_one_n_o,
    .port_b_bit_seven_i, .port_b_bit_seven_o, .pin_rx_sel_o, .pin_rx_sel_i, .async_one_receive_o,
    .async_one_transmit_i, .port_b_bit_six_i, .port_b_bit_six_o, .port_b_bit_five_i, .port_b_bit_five_o,
    .pin_b_six_o, .pin_b_six_i, .pin_b_five_o, .pin_b_five_i, .transfer_end_one_n_i, .clocked_serial_transmit_i,
    .clocked_serial_clock_i, .clocked_serial_clock_o, .chan_b_request_to_send_n_i, .chan_b_terminal_ready_req_n_i,
    .chan_b_wait_req_n_i, .host_receive_ready_n_i, .host_transmit_ready_n_i, .host_interrupt_i, .pin_tri_o,
    .pin_tri_i, .chan_b_transmit_data_i, .chan_b_receive_data_o, .chan_b_tx_rx_clock_i, .chan_b_tx_rx_clock_o,
    .chan_b_rx_tx_clock_i, .chan_b_rx_tx_clock_o, .chan_b_sync_i, .chan_b_sync_o, .chan_b_clear_to_send_n_o,
    .chan_b_carrier_detect_n_o, .host_driver_disable_n_i, .host_address_o, .host_chip_select_n_o,
    .host_write_strobe_n_o, .host_read_strobe_n_o, .pin_mode_o, .pin_mode_i, .port_a_byte_out_i,
    .port_a_byte_oe_i, .port_a_byte_o, .host_data_byte_out_i, .host_data_byte_oe_i, .host_data_byte_o,
    .pin_data_o, .pin_data_oe_o, .pin_data_i);

  mps_board #(.W(24)) i_board (.o_i(p_o), .oe_i(p_oe), .ext_i(ext), .lvl_o(p_lvl));

  // flatten the pin drives; bit 0 is the high address pin, data on top
  always_comb begin
    for (int i = 0; i < MODE_PINS; i++) begin
      m_o[i] = pin_mode_o[i].o;
      m_oe[i] = pin_mode_o[i].oe;
    end
    for (int i = 0; i < TRI_PINS; i++) begin
      t_o[i] = pin_tri_o[i].o;
      t_oe[i] = pin_tri_o[i].oe;
    end
  end
  assign p_o = {pin_data_o, m_o, t_o, pin_b_five_o.o, pin_b_six_o.o, pin_rx_sel_o.o, pin_clk_one_o.o,
    pin_clk_zero_o.o, pin_high_addr_o.o};
  assign p_oe = {pin_data_oe_o, m_oe, t_oe, pin_b_five_o.oe, pin_b_six_o.oe, pin_rx_sel_o.oe, pin_clk_one_o.oe,
    pin_clk_zero_o.oe, pin_high_addr_o.oe};
  assign {pin_data_i, pin_mode_i, pin_tri_i, pin_b_five_i, pin_b_six_i, pin_rx_sel_i, pin_clk_one_i,
    pin_clk_zero_i, pin_high_addr_i} = p_lvl;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // inputs move 2 ns after the edge, checks 1 ns later in the same cycle
  task automatic tick;
    @(posedge ref_clk_i);
    #2;
  endtask : tick

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // a hang costs at most 500 cycles; the tests need about 25
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end

  // main sequence; the triple pin sources make each set a distinct pattern
  initial begin
    tri_exp = '{3'b010, 3'b101, 3'b010, 3'b110};
    rst_n_i = 1'b0;
    ctrl_i = '1;
    ctrl_i.ext_bus_master = 1'b0;
    sys_cfg_i = 8'h06;
    {cpu_high_address_i, timer_out_i, transfer_end_zero_n_i, async_one_transmit_i} = 4'b1001;
    {transfer_end_one_n_i, clocked_serial_transmit_i, chan_b_request_to_send_n_i} = 3'b011;
    {chan_b_terminal_ready_req_n_i, chan_b_wait_req_n_i, host_receive_ready_n_i} = 3'b010;
    {host_transmit_ready_n_i, host_interrupt_i, chan_b_transmit_data_i, host_driver_disable_n_i} = 4'b1101;
    serial_clock_zero_i = '{o: 1'b0, oe: 1'b1};
    serial_clock_one_i = '{o: 1'b1, oe: 1'b1};
    clocked_serial_clock_i = '{o: 1'b0, oe: 1'b1};
    {port_b_bit_seven_i, port_b_bit_six_i, port_b_bit_five_i} = {3{DRV_OFF}};
    {chan_b_tx_rx_clock_i, chan_b_rx_tx_clock_i, chan_b_sync_i} = {3{DRV_OFF}};
    {port_a_byte_out_i, port_a_byte_oe_i, host_data_byte_out_i, host_data_byte_oe_i} = 32'ha5_0f_5a_f0;
    ext = {8'h3c, 7'h55, 9'h000};
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(pin_high_addr_o.o, 1'b1);
    chk(pin_clk_zero_o, serial_clock_zero_i);
    chk(pin_clk_one_o.o, 1'b1);
    chk(clocked_serial_receive_o, 1'b0);
    chk(t_o, 3'b010);
    chk({pin_mode_o[0].o, pin_data_oe_o}, 9'h00f);
    #1;
    rst_n_i = 1'b1;
    ctrl_i = '0;
    sys_cfg_i = '0;
    tick();
    for (int c = 0; c < 4; c++) begin
      tick();
      {ctrl_i.timer_out_ctrl_hi, ctrl_i.timer_out_ctrl_lo} = c[1:0];
      #1;
      chk(pin_high_addr_o.o, c == 0);
      chk(cs_high_address_o, 1'b1);
    end
    tick();
    ctrl_i.ext_bus_master = 1'b1;
    #1;
    chk({pin_high_addr_o.oe, cs_high_address_o}, 2'b00);
    for (int c = 0; c < 4; c++) begin
      tick();
      {ctrl_i.dest_mode_hi, ctrl_i.source_mode_hi} = c[1:0];
      #1;
      chk(dma_request_zero_n_o, c == 0);
      chk({pin_clk_zero_o.oe, serial_clock_zero_o}, {c == 0, c != 0});
    end
    for (int c = 0; c < 2; c++) begin
      tick();
      ctrl_i.serial_clock_one_disable = c[0];
      #1;
      chk(pin_clk_one_o.o, c == 0);
    end
    for (int c = 0; c < 4; c++) begin
      tick();
      {sys_cfg_i[CFG_PORT_B_HI_BIT], ctrl_i.clear_to_send_one_enable} = c[1:0];
      #1;
      chk({clear_to_send_one_n_o, clocked_serial_receive_o}, {c != 1, c != 0});
      chk(port_b_bit_seven_o, !c[1]);
      chk({port_b_bit_six_o, async_one_receive_o}, {!c[1], c[1]});
      chk({pin_b_five_o.o, pin_b_five_o.oe}, {2{!c[1]}});
    end
    for (int c = 0; c < 4; c++) begin
      tick();
      {sys_cfg_i[CFG_HOST_MODE_BIT], sys_cfg_i[CFG_CHAN_B_BIT]} = c[1:0];
      #1;
      chk(t_o, tri_exp[c]);
      chk(clocked_serial_clock_o, c[0]);
    end
    for (int h = 0; h < 2; h++) begin
      tick();
      sys_cfg_i = h ? 8'h02 : 8'h00;
      #1;
      chk({pin_mode_o[0].o, chan_b_receive_data_o, host_write_strobe_n_o}, h ? 3'b110 : 3'b001);
      chk({pin_data_o & pin_data_oe_o, pin_data_oe_o}, h ? 16'h50f0 : 16'h050f);
      chk({port_a_byte_o, host_data_byte_o}, h ? 16'hff5c : 16'h35ff);
      chk(host_address_o, h ? 3'b001 : 3'b111);
      chk({chan_b_tx_rx_clock_o, chan_b_rx_tx_clock_o, chan_b_clear_to_send_n_o}, h ? 3'b111 : 3'b100);
    end
    complete_run();
  end
endmodule : mps_pin_mux_test
`default_nettype wire
